//--- design/csm_pkg.sv
// Constants and types for the CPU state and privilege-mode controller
package csm_pkg;

  localparam int          CSM_AW            = 32;
  localparam logic [31:0] CSM_RESET_VECTOR  = 32'ha000_0000;
  localparam logic [31:0] CSM_SR_RESET      = 32'h7000_00f0;
  localparam int          CSM_SR_MD_BIT     = 30;
  localparam logic [31:0] CSM_VBR_RESET     = 32'h0000_0000;
  localparam logic [31:0] CSM_PC_STEP       = 32'h0000_0002;
  localparam logic [1:0]  CSM_PD_SLEEP      = 2'h0;
  localparam logic [1:0]  CSM_PD_SW_STANDBY = 2'h1;
  localparam logic [1:0]  CSM_PD_HW_STANDBY = 2'h2;
  localparam logic [1:0]  CSM_RST_NONE      = 2'h0;
  localparam logic [1:0]  CSM_RST_POWER_ON  = 2'h1;
  localparam logic [1:0]  CSM_RST_MANUAL    = 2'h2;
  localparam int          CSM_NUM_CTRL_REGS = 4;

  typedef enum logic [2:0] {
    CSM_ST_RESET,
    CSM_ST_EXCEPTION,
    CSM_ST_BUS_RELEASED,
    CSM_ST_EXECUTE,
    CSM_ST_POWER_DOWN
  } csm_state_e;

endpackage : csm_pkg

//--- design/csm_ctrl_regs.sv
// Small register file for the saved program counter and saved status word
`timescale 1ns/1ps
module csm_ctrl_regs #(
  parameter int DW = 32,
  parameter int AW = 2
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : csm_ctrl_regs

//--- design/csm_state_ctrl.sv
// Processor state, privilege mode, reset sources and exception entry control
//
// Contract
// RULE_01: Exactly five processor states: reset, exception, bus released, execute, power down.
// RULE_02: Low power-on reset pin holds the CPU in power-on reset.
// RULE_03: Low manual reset pin holds the CPU in manual reset.
// RULE_04: Power-on reset initialises CPU state and every supporting-module register.
// RULE_05: Manual reset initialises all but the external bus controller registers.
// RULE_06: After reset, fetching starts at the fixed reset address.
// RULE_07: Exception or interrupt saves program counter and status word.
// RULE_08: Handler address equals vector base plus event vector offset.
// RULE_09: Mode bit zero selects user mode, one selects privileged mode.
// RULE_10: Entering reset or exception state forces the mode bit to one.
// RULE_11: Exception return clears the mode bit and resumes in user mode.
// RULE_12: Designated registers are accessible only in privileged mode.
// RULE_13: Execution state runs instructions one after another in order.
// RULE_14: Power down halts the CPU: sleep, software standby, hardware standby.
// RULE_15: External bus request puts the CPU in bus released until returned.
// RULE_16: Reset is left only once both reset pins are high again.
`timescale 1ns/1ps
module csm_state_ctrl
  import csm_pkg::*;
#(
  parameter int AW = CSM_AW
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  // Reset pins
  input  wire logic          power_on_reset_n,
  input  wire logic          manual_reset_n,
  // Events from the pipeline
  input  wire logic          exc_req,
  input  wire logic [AW-1:0] exc_vec_offset,
  input  wire logic          exc_return,
  input  wire logic          instr_retire,
  input  wire logic [AW-1:0] branch_target,
  input  wire logic          branch_taken,
  // Power-down requests
  input  wire logic          sleep_req,
  input  wire logic          sw_standby_en,
  input  wire logic          hw_standby_n,
  input  wire logic          wakeup,
  // Bus arbitration pins
  input  wire logic          bus_req_n,
  output logic               bus_ack_n,
  // Control register access
  input  wire logic          ctrl_wr,
  input  wire logic          ctrl_rd,
  input  wire logic [1:0]    ctrl_sel,
  input  wire logic [AW-1:0] ctrl_wdata,
  output logic      [AW-1:0] ctrl_rdata,
  output logic               priv_violation,
  // Status
  output logic [2:0]         proc_state,
  output logic               privilege_mode_bit,
  output logic [AW-1:0]      status_word,
  output logic [AW-1:0]      fetch_pc,
  output logic               fetch_en,
  output logic [1:0]         pd_mode,
  output logic [1:0]         reset_cause,
  output logic               periph_init,
  output logic               bus_ctrl_init
);

  localparam logic [1:0] SEL_SPC = 2'h0;
  localparam logic [1:0] SEL_SSR = 2'h1;
  localparam logic [1:0] SEL_VBR = 2'h2;
  localparam logic [1:0] SEL_SR  = 2'h3;

  csm_state_e    state_q;
  csm_state_e    state_d;
  logic [1:0]    por_sync_q;
  logic [1:0]    mrst_sync_q;
  logic [1:0]    breq_sync_q;
  logic [1:0]    hwsb_sync_q;
  logic          por_low;
  logic          mrst_low;
  logic          breq;
  logic          hw_standby;
  logic [AW-1:0] pc_q;
  logic [AW-1:0] sr_q;
  logic [AW-1:0] vbr_q;
  logic [1:0]    rst_cause_q;
  logic [1:0]    pd_mode_q;
  logic          user_access;
  logic          rf_wr;
  logic [1:0]    rf_waddr;
  logic [AW-1:0] rf_wdata;
  logic [AW-1:0] rf_rdata;
  logic          exc_save;
  logic          is_priv;

  // Pins are asynchronous to core_clk, two stages before use
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_sync_q  <= 2'h0;
      mrst_sync_q <= 2'h0;
      breq_sync_q <= 2'h3;
      hwsb_sync_q <= 2'h3;
    end else begin
      por_sync_q  <= {por_sync_q[0], power_on_reset_n};
      mrst_sync_q <= {mrst_sync_q[0], manual_reset_n};
      breq_sync_q <= {breq_sync_q[0], bus_req_n};
      hwsb_sync_q <= {hwsb_sync_q[0], hw_standby_n};
    end
  end

  assign por_low    = !por_sync_q[1];
  assign mrst_low   = !mrst_sync_q[1];
  assign breq       = !breq_sync_q[1];
  assign hw_standby = !hwsb_sync_q[1];

  function automatic logic [AW-1:0] set_md(input logic [AW-1:0] sr, input logic md);
    logic [AW-1:0] r;
    r = sr;
    r[CSM_SR_MD_BIT] = md;
    return r;
  endfunction : set_md

  assign is_priv     = sr_q[CSM_SR_MD_BIT];                        // [RULE_09]
  assign user_access = (ctrl_wr || ctrl_rd) && !is_priv;
  // Only a taken exception saves; hardware standby and bus request outrank the request
  assign exc_save    = (state_q == CSM_ST_EXECUTE) && (state_d == CSM_ST_EXCEPTION); // [RULE_07]

  // Next state; reset pins win over everything, then hardware standby
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSM_ST_RESET: begin
        if (!por_low && !mrst_low) state_d = CSM_ST_EXCEPTION;    // [RULE_16]
      end
      CSM_ST_EXCEPTION: begin
        state_d = CSM_ST_EXECUTE;
      end
      CSM_ST_EXECUTE: begin
        if (hw_standby) state_d = CSM_ST_POWER_DOWN;              // [RULE_14]
        else if (breq) state_d = CSM_ST_BUS_RELEASED;             // [RULE_15]
        else if (exc_req) state_d = CSM_ST_EXCEPTION;
        else if (sleep_req) state_d = CSM_ST_POWER_DOWN;          // [RULE_14]
      end
      CSM_ST_BUS_RELEASED: begin
        if (!breq) state_d = CSM_ST_EXECUTE;                      // [RULE_15]
      end
      CSM_ST_POWER_DOWN: begin
        if (pd_mode_q == CSM_PD_HW_STANDBY) begin
          if (!hw_standby) state_d = CSM_ST_EXECUTE;
        end else if (wakeup) begin
          state_d = CSM_ST_EXECUTE;
        end
      end
      default: state_d = CSM_ST_RESET;
    endcase
    if (por_low || mrst_low) state_d = CSM_ST_RESET;              // [RULE_02] [RULE_03]
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CSM_ST_RESET;
    end else begin
      state_q <= state_d;                                          // [RULE_01]
    end
  end

  // Cause of the last reset, kept through the reset exception
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cause_q <= CSM_RST_POWER_ON;
    end else if (por_low) begin
      rst_cause_q <= CSM_RST_POWER_ON;
    end else if (mrst_low) begin
      rst_cause_q <= CSM_RST_MANUAL;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_mode_q <= CSM_PD_SLEEP;
    end else if (state_q == CSM_ST_EXECUTE && state_d == CSM_ST_POWER_DOWN) begin
      if (hw_standby) pd_mode_q <= CSM_PD_HW_STANDBY;             // [RULE_14]
      else if (sw_standby_en) pd_mode_q <= CSM_PD_SW_STANDBY;
      else pd_mode_q <= CSM_PD_SLEEP;
    end
  end

  // Program counter: reset vector, handler vector, sequential or branch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= CSM_RESET_VECTOR;
    end else if (state_q == CSM_ST_RESET) begin
      pc_q <= CSM_RESET_VECTOR;                                    // [RULE_06]
    end else if (exc_save) begin
      pc_q <= vbr_q + exc_vec_offset;                              // [RULE_08]
    end else if (state_q == CSM_ST_EXECUTE && exc_return) begin
      pc_q <= rf_rdata;
    end else if (state_q == CSM_ST_EXECUTE && instr_retire) begin
      pc_q <= branch_taken ? branch_target : pc_q + CSM_PC_STEP; // [RULE_13]
    end
  end

  // Status word and its mode bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_q <= CSM_SR_RESET;
    end else if (state_d == CSM_ST_RESET || exc_save) begin
      sr_q <= set_md(sr_q, 1'b1);                                  // [RULE_10] [RULE_04]
    end else if (state_q == CSM_ST_EXECUTE && exc_return) begin
      sr_q <= set_md(sr_q, 1'b0);                                  // [RULE_11]
    end else if (ctrl_wr && is_priv && ctrl_sel == SEL_SR) begin
      sr_q <= ctrl_wdata;                                          // [RULE_12]
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vbr_q <= CSM_VBR_RESET;
    end else if (state_q == CSM_ST_RESET) begin
      vbr_q <= CSM_VBR_RESET;                                      // [RULE_04] [RULE_05]
    end else if (ctrl_wr && is_priv && ctrl_sel == SEL_VBR) begin
      vbr_q <= ctrl_wdata;                                         // [RULE_12]
    end
  end

  // Saved copies: exception save uses two writes, PC first then SR
  logic          ssr_pend_q;
  logic [AW-1:0] ssr_val_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ssr_pend_q <= 1'b0;
      ssr_val_q  <= '0;
    end else begin
      ssr_pend_q <= exc_save;
      ssr_val_q  <= sr_q;                                          // [RULE_07]
    end
  end

  always_comb begin
    rf_wr    = 1'b0;
    rf_waddr = SEL_SPC;
    rf_wdata = '0;
    if (exc_save) begin
      rf_wr    = 1'b1;
      rf_waddr = SEL_SPC;
      rf_wdata = pc_q;                                             // [RULE_07]
    end else if (ssr_pend_q) begin
      rf_wr    = 1'b1;
      rf_waddr = SEL_SSR;
      rf_wdata = ssr_val_q;                                        // [RULE_07]
    end else if (ctrl_wr && is_priv && (ctrl_sel == SEL_SPC || ctrl_sel == SEL_SSR)) begin
      rf_wr    = 1'b1;
      rf_waddr = ctrl_sel;
      rf_wdata = ctrl_wdata;
    end
  end

  csm_ctrl_regs #(
    .DW(AW),
    .AW(2)
  ) u_regs (
    .core_clk(core_clk),
    .sys_rst (sys_rst),
    .wr_en   (rf_wr),
    .wr_addr (rf_waddr),
    .wr_data (rf_wdata),
    // Read port only serves the return path; registered data must already hold saved PC
    .rd_addr (SEL_SPC),
    .rd_data (rf_rdata)
  );

  // Read data registered; user-mode access reads zero and flags a violation
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_rdata     <= '0;
      priv_violation <= 1'b0;
    end else begin
      priv_violation <= user_access;                               // [RULE_12]
      if (ctrl_rd && is_priv) begin
        case (ctrl_sel)
          SEL_VBR: ctrl_rdata <= vbr_q;
          SEL_SR:  ctrl_rdata <= sr_q;
          default: ctrl_rdata <= '0;
        endcase
      end else begin
        ctrl_rdata <= '0;
      end
    end
  end

  assign proc_state         = state_q;
  assign privilege_mode_bit = sr_q[CSM_SR_MD_BIT];
  assign status_word        = sr_q;
  assign fetch_pc           = pc_q;
  assign fetch_en           = (state_q == CSM_ST_EXECUTE);
  assign pd_mode            = pd_mode_q;
  assign reset_cause        = rst_cause_q;
  assign bus_ack_n          = !(state_q == CSM_ST_BUS_RELEASED);
  assign periph_init        = (state_q == CSM_ST_RESET);           // [RULE_04] [RULE_05]
  assign bus_ctrl_init      = (state_q == CSM_ST_RESET) && por_low; // [RULE_05]

  // Assertions
  property p_por_hold;
    @(posedge core_clk) disable iff (sys_rst) por_low |=> state_q == CSM_ST_RESET;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por low but not in reset"); // [RULE_02]

  property p_mrst_hold;
    @(posedge core_clk) disable iff (sys_rst) mrst_low |=> state_q == CSM_ST_RESET;
  endproperty
  a_mrst_hold: assert property (p_mrst_hold) else $error("manual reset not held"); // [RULE_03]

  property p_reset_pc;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == CSM_ST_RESET) ##1 (state_q == CSM_ST_EXCEPTION) |-> pc_q == CSM_RESET_VECTOR;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset fetch address wrong"); // [RULE_06]

  property p_md_reset;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(state_q == CSM_ST_RESET) |-> privilege_mode_bit;
  endproperty
  a_md_reset: assert property (p_md_reset) else $error("mode bit not set on reset"); // [RULE_10]

  property p_exc_vector;
    @(posedge core_clk) disable iff (sys_rst)
      exc_save |=> pc_q == $past(vbr_q) + $past(exc_vec_offset) && privilege_mode_bit;
  endproperty
  a_exc_vector: assert property (p_exc_vector) else $error("handler address wrong"); // [RULE_08]

  property p_exc_ret;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == CSM_ST_EXECUTE && exc_return && !por_low && !mrst_low && !exc_req)
        |=> !privilege_mode_bit;
  endproperty
  a_exc_ret: assert property (p_exc_ret) else $error("mode bit not cleared"); // [RULE_11]

  property p_user_block;
    @(posedge core_clk) disable iff (sys_rst)
      (ctrl_rd && !is_priv) |=> ctrl_rdata == '0 && priv_violation;
  endproperty
  a_user_block: assert property (p_user_block) else $error("user access not blocked"); // [RULE_12]

  property p_leave_reset;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == CSM_ST_RESET) ##1 (state_q != CSM_ST_RESET)
        |-> !$past(por_low) && !$past(mrst_low);
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("reset left early"); // [RULE_16]

  property p_bus_rel;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == CSM_ST_BUS_RELEASED && breq && !por_low && !mrst_low)
        |=> state_q == CSM_ST_BUS_RELEASED && !bus_ack_n;
  endproperty
  a_bus_rel: assert property (p_bus_rel) else $error("bus taken back early"); // [RULE_15]

endmodule : csm_state_ctrl

//--- testbench/csm_ext_party.sv
// External reset sources and a bus-requesting master facing the state controller
`timescale 1ns/1ps
module csm_ext_party #(
  parameter int HOLD = 5
) (
  // Clock
  input  wire logic core_clk,
  // Commands from the bench
  input  wire logic por_hold,
  input  wire logic man_hold,
  input  wire logic bus_go,
  // Pins
  input  wire logic bus_ack_n,
  output logic      power_on_reset_n,
  output logic      manual_reset_n,
  output logic      bus_req_n
);
  int own_cnt = 0;

  initial begin
    power_on_reset_n = 1'b0;
    manual_reset_n = 1'b1;
    bus_req_n = 1'b1;
  end

  // Plain level holders, low for as long as the bench asks
  always @(posedge core_clk) begin
    power_on_reset_n <= ~por_hold;
    manual_reset_n <= ~man_hold;
  end

  // Request stays low until the grant was used for HOLD cycles
  always @(posedge core_clk) begin
    if (bus_go && bus_req_n) begin
      bus_req_n <= 1'b0;
      own_cnt <= 0;
    end else if (!bus_req_n && !bus_ack_n) begin
      own_cnt <= own_cnt + 1;
      if (own_cnt == HOLD - 1)
        bus_req_n <= 1'b1;
    end
  end
endmodule : csm_ext_party

//--- testbench/cpu_state_and_mode_control_bench.sv
// Self-checking bench for the CPU state and privilege-mode controller
`timescale 1ns/1ps
module cpu_state_and_mode_control_bench;
  import csm_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, por_hold = 1'b1, man_hold = 1'b0;
  logic        exc_req = 1'b0, exc_return = 1'b0, instr_retire = 1'b0, branch_taken = 1'b0;
  logic        sleep_req = 1'b0, sw_standby_en = 1'b0, hw_standby_n = 1'b1, wakeup = 1'b0;
  logic        ctrl_wr = 1'b0, ctrl_rd = 1'b0, bus_go = 1'b0, snap = 1'b0, rd_dly;
  logic [1:0]  ctrl_sel = 2'h0, pd_mode, reset_cause;
  logic [31:0] exc_vec_offset = 32'h0, branch_target = 32'h0, ctrl_wdata = 32'h0;
  logic [31:0] ctrl_rdata, fetch_pc, seed = 32'h2d, r1, t, o, status_word, w;
  logic [2:0]  proc_state, prev, e;
  logic        power_on_reset_n, manual_reset_n, bus_req_n, bus_ack_n;
  logic        priv_violation, privilege_mode_bit, periph_init, bus_ctrl_init, fetch_en;
  int          err_count = 0, compares = 0, n;
  // Logic queues so that an unexpected event pops an unknown and fails
  logic [2:0]  st_q[$];
  logic [31:0] aux_q[$];
  logic [32:0] snap_q[$], rd_q[$], s;

  always #2 core_clk = ~core_clk;

  csm_ext_party #(.HOLD(5)) party_u (.core_clk(core_clk), .por_hold(por_hold),
    .man_hold(man_hold), .bus_go(bus_go), .bus_ack_n(bus_ack_n),
    .power_on_reset_n(power_on_reset_n), .manual_reset_n(manual_reset_n), .bus_req_n(bus_req_n));

  csm_state_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .power_on_reset_n(power_on_reset_n), .manual_reset_n(manual_reset_n), .exc_req(exc_req),
    .exc_vec_offset(exc_vec_offset), .exc_return(exc_return), .instr_retire(instr_retire),
    .branch_target(branch_target), .branch_taken(branch_taken), .sleep_req(sleep_req),
    .sw_standby_en(sw_standby_en), .hw_standby_n(hw_standby_n), .wakeup(wakeup),
    .bus_req_n(bus_req_n), .bus_ack_n(bus_ack_n), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd),
    .ctrl_sel(ctrl_sel), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .priv_violation(priv_violation), .proc_state(proc_state), .status_word(status_word),
    .privilege_mode_bit(privilege_mode_bit), .fetch_pc(fetch_pc), .fetch_en(fetch_en),
    .pd_mode(pd_mode), .reset_cause(reset_cause), .periph_init(periph_init),
    .bus_ctrl_init(bus_ctrl_init));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic cmp_word(string what, logic [32:0] exp, logic [32:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_state(logic [2:0] exp, logic [2:0] got);
    cmp_word("proc_state", {30'h0, exp}, {30'h0, got});
  endtask : cmp_state

  task automatic expect_st(csm_state_e s, logic [31:0] a);
    st_q.push_back(s);
    if (s inside {CSM_ST_RESET, CSM_ST_EXCEPTION, CSM_ST_POWER_DOWN})
      aux_q.push_back(a);
  endtask : expect_st

  // Bounded wait until every announced state change has been seen
  task automatic settle();
    int k;
    k = 0;
    while (st_q.size() != 0 && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 300) begin
      err_count++;
      final_report();
    end
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic ctrl(logic wr, logic [1:0] sel, logic [31:0] d);
    ctrl_wr <= wr;
    ctrl_rd <= ~wr;
    ctrl_sel <= sel;
    ctrl_wdata <= d;
    @(posedge core_clk);
    ctrl_wr <= 1'b0;
    ctrl_rd <= 1'b0;
    @(posedge core_clk);
  endtask : ctrl

  task automatic check_pc(logic [32:0] v);
    snap_q.push_back(v);
    instr_retire <= 1'b0;
    branch_taken <= 1'b0;
    snap <= 1'b1;
    @(posedge core_clk);
    snap <= 1'b0;
    @(posedge core_clk);
  endtask : check_pc

  task automatic take_exc(logic [31:0] off, logic [31:0] vec);
    expect_st(CSM_ST_EXCEPTION, vec);
    expect_st(CSM_ST_EXECUTE, 32'h0);
    exc_req <= 1'b1;
    exc_vec_offset <= off;
    @(posedge core_clk);
    exc_req <= 1'b0;
    settle();
  endtask : take_exc

  // Watcher: registered results are seen one edge after they land
  always @(posedge core_clk) begin
    if (sys_rst) begin
      prev = CSM_ST_RESET;
      rd_dly = 1'b0;
    end else begin
      if (rd_dly)
        cmp_word("ctrl_read", rd_q.pop_front(), {priv_violation, ctrl_rdata});
      rd_dly = ctrl_rd;
      if (snap) begin
        s = snap_q.pop_front();
        cmp_word("mode_pc", s, {privilege_mode_bit, fetch_pc});
        w = CSM_SR_RESET;
        w[CSM_SR_MD_BIT] = s[32];
        cmp_word("status_word", {1'b0, w}, {1'b0, status_word});
      end
      if (proc_state !== prev) begin
        e = st_q.pop_front();
        cmp_state(e, proc_state);
        cmp_word("fetch_bus", {31'h0, e == CSM_ST_EXECUTE, e != CSM_ST_BUS_RELEASED},
          {31'h0, fetch_en, bus_ack_n});
        if (proc_state == CSM_ST_EXCEPTION)
          cmp_word("vector", {1'b1, aux_q.pop_front()}, {privilege_mode_bit, fetch_pc});
        if (proc_state == CSM_ST_RESET)
          cmp_word("reset_info", {1'b1, aux_q.pop_front()},
            {privilege_mode_bit, 28'h0, bus_ctrl_init, periph_init, reset_cause});
        if (proc_state == CSM_ST_POWER_DOWN)
          cmp_word("pd_mode", {1'b0, aux_q.pop_front()}, {31'h0, pd_mode});
        prev = proc_state;
      end
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    expect_st(CSM_ST_EXCEPTION, CSM_RESET_VECTOR);
    expect_st(CSM_ST_EXECUTE, 32'h0);
    por_hold <= 1'b0;
    settle();
    r1 = rnd();
    ctrl(1'b1, 2'h2, r1);
    rd_q.push_back({1'b0, r1});
    ctrl(1'b0, 2'h2, 32'h0);
    rd_q.push_back({1'b0, CSM_SR_RESET});
    ctrl(1'b0, 2'h3, 32'h0);
    n = int'(rnd() % 4) + 1;
    instr_retire <= 1'b1;
    repeat (n) @(posedge core_clk);
    check_pc({1'b1, CSM_RESET_VECTOR + CSM_PC_STEP * 32'(n)});
    t = rnd() & 32'hffff_fffe;
    instr_retire <= 1'b1;
    branch_taken <= 1'b1;
    branch_target <= t;
    @(posedge core_clk);
    check_pc({1'b1, t});
    o = rnd() & 32'h0000_0ffc;
    take_exc(o, r1 + o);
    exc_return <= 1'b1;
    @(posedge core_clk);
    exc_return <= 1'b0;
    repeat (2) @(posedge core_clk);
    check_pc({1'b0, t});
    // User mode: the write must be dropped, so the next vector still uses r1
    ctrl(1'b1, 2'h2, ~r1);
    rd_q.push_back({1'b1, 32'h0});
    ctrl(1'b0, 2'h2, 32'h0);
    o = rnd() & 32'h0000_0ffc;
    take_exc(o, r1 + o);
    rd_q.push_back({1'b0, r1});
    ctrl(1'b0, 2'h2, 32'h0);
    expect_st(CSM_ST_BUS_RELEASED, 32'h0);
    expect_st(CSM_ST_EXECUTE, 32'h0);
    bus_go <= 1'b1;
    @(posedge core_clk);
    bus_go <= 1'b0;
    settle();
    for (int m = 0; m < 2; m++) begin
      expect_st(CSM_ST_POWER_DOWN, 32'(m));
      expect_st(CSM_ST_EXECUTE, 32'h0);
      sw_standby_en <= m[0];
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      repeat (20) @(posedge core_clk);
      wakeup <= 1'b1;
      @(posedge core_clk);
      wakeup <= 1'b0;
      settle();
    end
    expect_st(CSM_ST_POWER_DOWN, {30'h0, CSM_PD_HW_STANDBY});
    hw_standby_n <= 1'b0;
    settle();
    expect_st(CSM_ST_RESET, {28'h0, 2'b01, CSM_RST_MANUAL});
    man_hold <= 1'b1;
    settle();
    hw_standby_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    expect_st(CSM_ST_EXCEPTION, CSM_RESET_VECTOR);
    expect_st(CSM_ST_EXECUTE, 32'h0);
    man_hold <= 1'b0;
    settle();
    expect_st(CSM_ST_RESET, {28'h0, 2'b11, CSM_RST_POWER_ON});
    por_hold <= 1'b1;
    settle();
    // Manual pin still low after power-on is released: must stay in reset
    man_hold <= 1'b1;
    repeat (10) @(posedge core_clk);
    por_hold <= 1'b0;
    repeat (20) @(posedge core_clk);
    expect_st(CSM_ST_EXCEPTION, CSM_RESET_VECTOR);
    expect_st(CSM_ST_EXECUTE, 32'h0);
    man_hold <= 1'b0;
    settle();
    final_report();
  end
endmodule : cpu_state_and_mode_control_bench
